// ==== testbench/gib_register_bank_props.sv ====
`timescale 1ns/10ps
`include "gib_map.vh"
module gib_register_bank_props (
   input wire clock,
   input wire rst_b,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_rdata,
   input wire fast_fill_active,
   input wire fast_fill_command_bit0,
   input wire dither_enable,
   input wire [4:0] outstanding_count,
   input wire [3:0] pending_request_count,
   input wire [3:0] returned_data_count,
   input wire memory_kind_sdram,
   input wire [2:0] memory_density,
   input wire memory_chip_count,
   input wire dither_active,
   input wire port_high_priority,
   input wire request_queue_full,
   input wire port_request_stall,
   input wire refresh_on_hblank
);
   reg [31:0] pr;
   wire [2:0] full_thr = pr[6:4];
   wire [3:0] fill_thr = pr[10:7];
   wire mapped = reg_addr inside {`GIB_OFF_MEM_FIRST, `GIB_OFF_MEM_SECOND,
      `GIB_OFF_PORT_REQ, `GIB_OFF_FIFO_TRIM, `GIB_OFF_LEGACY_A,
      `GIB_OFF_LEGACY_B};
   wire wr_pr = reg_write && reg_addr == `GIB_OFF_PORT_REQ;
   wire wr_a = reg_write && reg_addr == `GIB_OFF_LEGACY_A;
   wire wr_m2 = reg_write && reg_addr == `GIB_OFF_MEM_SECOND;
   // ----------------------------------------
   // port request shadow
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pr <= `GIB_RST_PORT_REQ;
      end else if (wr_pr) begin
         pr <= reg_wdata;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_rdata_quiet;
      !(reg_read && mapped) |=> reg_rdata == 32'h0;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet)
      else $error("read data not zero");
   property p_mem_kind;
      wr_m2 |-> ##2 memory_kind_sdram == $past(reg_wdata[30], 2);
   endproperty
   a_mem_kind: assert property (p_mem_kind)
      else $error("memory kind wrong");
   property p_sdram_parts;
      memory_kind_sdram |-> memory_density == `GIB_DENS_16MBIT
         && !memory_chip_count;
   endproperty
   a_sdram_parts: assert property (p_sdram_parts)
      else $error("density not forced");
   property p_fill_dither;
      dither_enable && fast_fill_active && fast_fill_command_bit0
         |=> dither_active == memory_kind_sdram;
   endproperty
   a_fill_dither: assert property (p_fill_dither)
      else $error("fast fill dither wrong");
   property p_prio;
      wr_pr |-> ##2 port_high_priority == $past(reg_wdata[0], 2);
   endproperty
   a_prio: assert property (p_prio)
      else $error("priority wrong");
   property p_full;
      $past(rst_b) |-> request_queue_full ==
         ($past(pending_request_count) >= $past(full_thr));
   endproperty
   a_full: assert property (p_full)
      else $error("queue full wrong");
   property p_stall;
      $past(rst_b) |-> port_request_stall ==
         ($past(returned_data_count) > $past(fill_thr));
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall wrong");
   property p_outst;
      !wr_pr && reg_read && reg_addr == `GIB_OFF_PORT_REQ
         && (outstanding_count == 5'h0 || outstanding_count == 5'h11)
         |=> reg_rdata[31:27] ==
         (($past(outstanding_count) == 5'h0) ? 5'h1f : 5'h0);
   endproperty
   a_outst: assert property (p_outst)
      else $error("outstanding code wrong");
   property p_refresh;
      wr_a |-> ##2 refresh_on_hblank == !$past(reg_wdata[22], 2);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh policy wrong");
   c_sdram_fill: cover property (memory_kind_sdram && fast_fill_active);
   c_full_stall: cover property (request_queue_full && port_request_stall);
   c_unmapped: cover property (reg_read && !mapped);
endmodule
bind gib_register_bank gib_register_bank_props gib_register_bank_props_i (
   .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .fast_fill_active(fast_fill_active),
   .fast_fill_command_bit0(fast_fill_command_bit0),
   .dither_enable(dither_enable), .outstanding_count(outstanding_count),
   .pending_request_count(pending_request_count),
   .returned_data_count(returned_data_count),
   .memory_kind_sdram(memory_kind_sdram), .memory_density(memory_density),
   .memory_chip_count(memory_chip_count), .dither_active(dither_active),
   .port_high_priority(port_high_priority),
   .request_queue_full(request_queue_full),
   .port_request_stall(port_request_stall),
   .refresh_on_hblank(refresh_on_hblank));

// ==== testbench/test_graphics_init_register_bank.sv ====
`timescale 1ns/10ps
`include "gib_map.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_graphics_init_register_bank;
   reg clock = 0, rst_b = 0, reg_write = 0, reg_read = 0;
   reg [7:0] reg_addr = 0;
   reg [31:0] reg_wdata = 0, seed = 32'hcab6997f;
   reg fast_fill_active = 0, fast_fill_command_bit0 = 0, dither_enable = 0;
   reg [4:0] outstanding_count = 0;
   reg [3:0] pending_request_count = 0, returned_data_count = 0;
   reg [3:0] texture_free_space = 0, pixel_free_space = 0;
   reg [9:0] strap = 10'h2a5;
   reg [31:0] m1, m2, pr, ft, la, lb;
   reg [95:0] e;
   reg [2:0] en;
   wire [95:0] o;
   wire [31:0] reg_rdata;
   integer n_mismatch = 0, cmp_count = 0, i;
   gib_register_bank gib_register_bank_i (.clock(clock), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .strap_vga_disable(strap[0]), .strap_decode_off(strap[1]),
      .strap_wake_select(strap[2]), .strap_chip_count(strap[3]),
      .strap_density(strap[6:4]), .strap_port_config(strap[9:7]),
      .fast_fill_active(fast_fill_active), .dither_enable(dither_enable),
      .fast_fill_command_bit0(fast_fill_command_bit0),
      .outstanding_count(outstanding_count),
      .pending_request_count(pending_request_count),
      .returned_data_count(returned_data_count),
      .texture_free_space(texture_free_space),
      .pixel_free_space(pixel_free_space), .memory_kind_sdram(o[0]),
      .read_to_precharge_delay(o[2:1]), .memory_density(o[5:3]),
      .memory_chip_count(o[6]), .dither_active(o[7]),
      .port_high_priority(o[8]), .request_queue_full(o[9]),
      .port_request_stall(o[10]), .texture_sequence_active(o[11]),
      .pixel_sequence_start(o[12]), .texture_read_limit_off(o[13]),
      .texture_min_reads_three(o[14]), .texture_force_miss(o[15]),
      .tv_clock_invert(o[16]), .tv_clock_delay(o[20:17]),
      .antialias_clock_invert(o[21]), .antialias_clock_delay(o[25:22]),
      .memory_port_layout(o[28:26]), .vga_core_disable(o[29]),
      .palette_width_8bit(o[30]), .legacy_decode_off(o[31]),
      .enable_port_write_block(o[32]), .wake_port_motherboard(o[33]),
      .config_readback_enable(o[34]), .raster_fetch_off(o[35]),
      .vga_base_address(o[61:36]), .refresh_on_hblank(o[62]),
      .bios_extension_write_aperture(o[74:63]),
      .bios_extension_read_aperture(o[86:75]),
      .chain4_sequential(o[87]), .timing_lock(o[95:88]));
   always #2 clock = ~clock;
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [31:0] rexp(input [7:0] a);
      reg [4:0] n;
      begin
         n = outstanding_count;
         case (a)
            `GIB_OFF_MEM_FIRST: rexp = m1;
            `GIB_OFF_MEM_SECOND: rexp = m2;
            `GIB_OFF_PORT_REQ: rexp = pr | {((n == 5'h0) ? 5'h1f :
               (n > 5'h11) ? 5'h0 : 5'h11 - n), 27'h0};
            `GIB_OFF_FIFO_TRIM: rexp = ft;
            `GIB_OFF_LEGACY_A: rexp = la;
            `GIB_OFF_LEGACY_B: rexp = lb;
            default: rexp = 32'h0;
         endcase
      end
   endfunction
   // ----------------------------------------
   // random status inputs
   // ----------------------------------------
   always @(posedge clock) begin
      seed <= xs(seed);
      {fast_fill_active, fast_fill_command_bit0, dither_enable,
         pending_request_count, returned_data_count, texture_free_space,
         pixel_free_space} <= seed[18:0];
   end
   // ----------------------------------------
   // register shadow and expected outputs
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         m1 <= `GIB_RST_MEM_FIRST;
         m2 <= `GIB_RST_MEM_SECOND;
         pr <= `GIB_RST_PORT_REQ;
         ft <= `GIB_RST_FIFO_TRIM;
         la <= `GIB_RST_LEGACY_A;
         lb <= `GIB_RST_LEGACY_B;
         en <= 3'h0;
         e <= 96'h0;
      end else begin
         en <= en + {2'h0, en != 3'h7};
         if (en == 3'h2) begin
            m1 <= m1 | {2'h0, strap[6:3], 26'h0};
            ft <= ft | {4'h0, strap[9:7], 25'h0};
            la <= la | {22'h0, strap[2], strap[2], 4'h0, strap[1], 2'h0,
               strap[0]};
         end else if (reg_write) begin
            case (reg_addr)
               `GIB_OFF_MEM_FIRST: m1 <= reg_wdata & `GIB_MASK_MEM_FIRST;
               `GIB_OFF_MEM_SECOND: m2 <= reg_wdata & `GIB_MASK_MEM_SECOND;
               `GIB_OFF_PORT_REQ: pr <= reg_wdata & `GIB_MASK_PORT_REQ;
               `GIB_OFF_FIFO_TRIM: ft <= reg_wdata & `GIB_MASK_FIFO_TRIM;
               `GIB_OFF_LEGACY_A: la <= reg_wdata & `GIB_MASK_LEGACY_A;
               `GIB_OFF_LEGACY_B: lb <= reg_wdata & `GIB_MASK_LEGACY_B;
               default: ;
            endcase
         end
         e <= {lb[28:20], la[26:25], lb[19:10], lb[30:29], lb[9:0], ~la[22],
            la[24:23], la[21:14], 16'h0, la[12], ~la[10], la[8], la[9],
            la[9] | la[3], la[2], la[0], ft[27:12],
            pixel_free_space < ft[11:8], e[11] ? texture_free_space <
            ft[3:0] : texture_free_space < ft[7:4],
            returned_data_count > pr[10:7],
            pending_request_count >= pr[6:4], pr[0], dither_enable &
            ~(fast_fill_active & fast_fill_command_bit0 & ~m2[30]),
            m2[30] ? 4'h1 : {m1[26], m1[29:27]}, m2[31], m1[22], m2[30]};
      end
   end
   always @(negedge clock) begin
      if (rst_b && en != 3'h0) begin
         `CHK("kind", e[0], o[0])
         `CHK("rd_pre", e[2:1], o[2:1])
         `CHK("density", e[6:3], o[6:3])
         `CHK("dither", e[7], o[7])
         `CHK("prio", e[8], o[8])
         `CHK("full", e[9], o[9])
         `CHK("stall", e[10], o[10])
         `CHK("marks", e[12:11], o[12:11])
         `CHK("tex_ctl", e[15:13], o[15:13])
         `CHK("clk_trim", e[25:16], o[25:16])
         `CHK("layout", e[28:26], o[28:26])
         `CHK("vga_off", e[29], o[29])
         `CHK("palette", e[30], o[30])
         `CHK("decode", e[32:31], o[32:31])
         `CHK("wake", e[33], o[33])
         `CHK("cfg_rb", e[34], o[34])
         `CHK("fetch", e[35], o[35])
         `CHK("base", e[61:36], o[61:36])
         `CHK("refresh", e[62], o[62])
         `CHK("aperture", e[87:63], o[87:63])
         `CHK("lock", e[95:88], o[95:88])
      end
   end
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock);
         reg_addr <= a;
         reg_wdata <= d;
         reg_write <= 1'b1;
         @(posedge clock);
         reg_write <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge clock);
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clock);
         reg_read <= 1'b0;
         #1;
         `CHK("rdata", rexp(a), reg_rdata)
      end
   endtask
   task restart;
      begin
         repeat (2) @(posedge clock);
         rst_b <= 1'b1;
         repeat (3) @(posedge clock);
         for (i = 0; i < 6; i = i + 1) begin
            rd(8'(8'h18 + 4 * i));
         end
      end
   endtask
   task end_of_test;
      begin
         if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_mismatch++;
      end_of_test;
   end
   initial begin
      restart;
      for (i = 0; i < 30; i = i + 1) begin
         @(posedge clock);
         outstanding_count <= (i == 8) ? 5'h0 : (i == 2) ? 5'h11 : seed[4:0];
         wr(8'(8'h18 + 4 * (i % 6)), (i < 6) ? 32'hffff_ffff : (i < 12) ?
            32'h0 : seed);
         rd(8'(8'h18 + 4 * (i % 6)));
         rd(8'((i % 2) ? 8'h30 + i : 8'h14 - i));
      end
      @(posedge clock);
      strap <= ~strap;
      rst_b <= 1'b0;
      restart;
      repeat (400) @(posedge clock);
      end_of_test;
   end
endmodule

// ==== verilog/gib_map.vh ====
`ifndef GIB_MAP_VH
`define GIB_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define GIB_OFF_MEM_FIRST 8'h18
`define GIB_OFF_MEM_SECOND 8'h1c
`define GIB_OFF_PORT_REQ 8'h20
`define GIB_OFF_FIFO_TRIM 8'h24
`define GIB_OFF_LEGACY_A 8'h28
`define GIB_OFF_LEGACY_B 8'h2c
// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define GIB_MASK_MEM_FIRST 32'h3c40_0000
`define GIB_MASK_MEM_SECOND 32'hc000_0000
`define GIB_MASK_PORT_REQ 32'h0000_07f1
`define GIB_MASK_FIFO_TRIM 32'h0fff_ffff
`define GIB_MASK_LEGACY_A 32'h07ff_ffcf
`define GIB_MASK_LEGACY_B 32'h7fff_ffff
`define GIB_RST_MEM_FIRST 32'h0040_0000
`define GIB_RST_MEM_SECOND 32'h0000_0000
`define GIB_RST_PORT_REQ 32'h0000_0490
`define GIB_RST_FIFO_TRIM 32'h0000_0bfb
`define GIB_RST_LEGACY_A 32'h0040_0004
`define GIB_RST_LEGACY_B 32'h0000_0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define GIB_M1_TRL_LO 22
`define GIB_M1_CHIPS 26
`define GIB_M1_DENS 29:27
`define GIB_M2_SDRAM 30
`define GIB_M2_TRL_HI 31
`define GIB_PR_PRIO 0
`define GIB_PR_FULL 6:4
`define GIB_PR_FILL 10:7
`define GIB_PR_OUTST 31:27
`define GIB_FT_TEX_LOW 3:0
`define GIB_FT_TEX_HIGH 7:4
`define GIB_FT_PIX_HIGH 11:8
`define GIB_FT_NO_LIMIT 12
`define GIB_FT_MIN3 13
`define GIB_FT_MISS 14
`define GIB_FT_TV_INV 15
`define GIB_FT_TV_DEL 19:16
`define GIB_FT_AA_INV 20
`define GIB_FT_AA_DEL 24:21
`define GIB_FT_PORT_CFG 27:25
`define GIB_LA_DISABLE 0
`define GIB_LA_CLUT8 2
`define GIB_LA_DEC_OFF 3
`define GIB_LA_WAKE 8
`define GIB_LA_LEG_OFF 9
`define GIB_LA_CFG_OFF 10
`define GIB_LA_NO_FETCH 12
`define GIB_LA_BASE_LO 21:14
`define GIB_LA_REF_TMO 22
`define GIB_LA_BASE_HI 24:23
`define GIB_LA_RD_HI 26:25
`define GIB_LB_WR_LO 9:0
`define GIB_LB_RD_LO 19:10
`define GIB_LB_CHAIN4 20
`define GIB_LB_LOCKS 28:21
`define GIB_LB_WR_HI 30:29
// ----------------------------------------
// constants
// ----------------------------------------
`define GIB_DENS_16MBIT 3'h1
`define GIB_OUTST_NONE 5'h1f
`define GIB_OUTST_MAX 5'h11
`define GIB_STRAP_LOAD 2'h2
`endif

// ==== verilog/gib_register_bank.v ====
`timescale 1ns/10ps
`include "gib_map.vh"

// What this block does
// RQ1: second memory setup bit 30 selects memory kind, 1 plain DRAM, resets 0.
// RQ2: read-to-precharge delay is {second[31], first[22]}, reset code 1.
// RQ3: plain DRAM forces 16Mbit parts; density and chip count fields ignored.
// RQ4: fast fill with command bit 0 suppresses dither only for graphics RAM.
// RQ5: port request bit 0 forces high request priority, resets 0.
// RQ6: port request field 6:4 sets queue full level, resets 1.
// RQ7: field 10:7 sets returned data threshold; above it requests stall.
// RQ8: read-only field 31:27 shows outstanding requests, 1f none, 0 seventeen or more.
// RQ9: texture unit starts at high mark, drains to low mark; pixel mark.
// RQ10: bits 12..14: no read limit, minimum three reads, force misses.
// RQ11: tv and antialias clocks each get invert bit and 4-bit delay.
// RQ12: field 27:25 is memory port layout, reset from straps.
// RQ13: legacy setup bit 0 shuts off all VGA core access, strap reset.
// RQ14: bit 2 picks 8-bit palette lookup, resets 1.
// RQ15: bit 9 disables legacy decode and blocks enable port writes.
// RQ16: bit 8 selects motherboard wake port, strap reset.
// RQ17: bit 10 low enables config read-back via extended CRT index.
// RQ18: bit 12 stops VGA memory fetches during raster shift-out.
// RQ19: VGA base is 26-bit {24:23, 21:14, sixteen zeros}, reset zero.
// RQ20: bit 22 low gives three refreshes after blank; high timeout only.
// RQ21: second setup holds write aperture, chain-4 enable and read aperture low 10 bits; read aperture top bits are first setup 26:25.
// RQ22: bits 28:21 each lock writes to one timing group, reset unlocked.
// RQ23: reserved bits read zero and ignore writes.
module gib_register_bank (
   input wire clock,
   input wire rst_b,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,

   input wire strap_vga_disable,
   input wire strap_decode_off,
   input wire strap_wake_select,
   input wire strap_chip_count,
   input wire [2:0] strap_density,
   input wire [2:0] strap_port_config,
   input wire fast_fill_active,
   input wire fast_fill_command_bit0,
   input wire dither_enable,
   input wire [4:0] outstanding_count,
   input wire [3:0] pending_request_count,
   input wire [3:0] returned_data_count,
   input wire [3:0] texture_free_space,
   input wire [3:0] pixel_free_space,

   output reg memory_kind_sdram,
   output reg [1:0] read_to_precharge_delay,
   output reg [2:0] memory_density,
   output reg memory_chip_count,
   output reg dither_active,

   output reg port_high_priority,
   output reg request_queue_full,
   output reg port_request_stall,
   output reg texture_sequence_active,
   output reg pixel_sequence_start,
   output reg texture_read_limit_off,
   output reg texture_min_reads_three,
   output reg texture_force_miss,
   output reg tv_clock_invert,
   output reg [3:0] tv_clock_delay,
   output reg antialias_clock_invert,
   output reg [3:0] antialias_clock_delay,
   output reg [2:0] memory_port_layout,

   output reg vga_core_disable,
   output reg palette_width_8bit,
   output reg legacy_decode_off,
   output reg enable_port_write_block,
   output reg wake_port_motherboard,
   output reg config_readback_enable,
   output reg raster_fetch_off,
   output reg [25:0] vga_base_address,
   output reg refresh_on_hblank,
   output reg [11:0] bios_extension_write_aperture,
   output reg [11:0] bios_extension_read_aperture,
   output reg chain4_sequential,
   output reg [7:0] timing_lock
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [31:0] merge;
      input [31:0] old_value;
      input [31:0] new_value;
      input [31:0] mask;
      begin
         merge = (old_value & ~mask) | (new_value & mask);
      end
   endfunction

   function [4:0] outstanding_code;
      input [4:0] count;
      begin
         if (count == 5'h00) begin
            outstanding_code = `GIB_OUTST_NONE;
         end else if (count >= `GIB_OUTST_MAX) begin
            outstanding_code = 5'h00;
         end else begin
            outstanding_code = `GIB_OUTST_MAX - count;
         end
      end
   endfunction

   // ----------------------------------------
   // strap synchronisers and load
   // ----------------------------------------
   reg [9:0] strap_meta;
   reg [9:0] strap_sync;
   reg [1:0] strap_wait;
   reg strap_loaded;
   wire strap_load;

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strap_meta <= 10'h000;
         strap_sync <= 10'h000;
         strap_wait <= 2'h0;
         strap_loaded <= 1'b0;
      end else begin
         strap_meta <= {strap_vga_disable, strap_decode_off,
            strap_wake_select, strap_chip_count, strap_density,
            strap_port_config};
         strap_sync <= strap_meta;

         if (!strap_loaded) begin
            strap_wait <= strap_wait + 2'h1;
         end
         if (strap_wait == `GIB_STRAP_LOAD) begin
            strap_loaded <= 1'b1;
         end
      end
   end

   // straps reach the registers once the sync stages hold pin values
   assign strap_load = !strap_loaded && (strap_wait == `GIB_STRAP_LOAD);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   reg [31:0] mem_first;
   reg [31:0] mem_second;
   reg [31:0] port_req;
   reg [31:0] fifo_trim;
   reg [31:0] legacy_a;
   reg [31:0] legacy_b;
   reg [31:0] next_rdata;

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_first <= `GIB_RST_MEM_FIRST;
         mem_second <= `GIB_RST_MEM_SECOND; // RQ1
         port_req <= `GIB_RST_PORT_REQ; // RQ5
         fifo_trim <= `GIB_RST_FIFO_TRIM;
         legacy_a <= `GIB_RST_LEGACY_A;
         legacy_b <= `GIB_RST_LEGACY_B; // RQ22

      end else if (strap_load) begin
         mem_first[`GIB_M1_CHIPS] <= strap_sync[6];
         mem_first[`GIB_M1_DENS] <= strap_sync[5:3];
         fifo_trim[`GIB_FT_PORT_CFG] <= strap_sync[2:0]; // RQ12
         legacy_a[`GIB_LA_DISABLE] <= strap_sync[9]; // RQ13
         legacy_a[`GIB_LA_DEC_OFF] <= strap_sync[8];
         legacy_a[`GIB_LA_WAKE] <= strap_sync[7]; // RQ16
         legacy_a[`GIB_LA_LEG_OFF] <= strap_sync[7];

      end else if (reg_write) begin
         case (reg_addr)
            `GIB_OFF_MEM_FIRST: begin
               mem_first <= merge(mem_first, reg_wdata,
                  `GIB_MASK_MEM_FIRST); // RQ23
            end
            `GIB_OFF_MEM_SECOND: begin
               mem_second <= merge(mem_second, reg_wdata,
                  `GIB_MASK_MEM_SECOND); // RQ23
            end
            `GIB_OFF_PORT_REQ: begin
               port_req <= merge(port_req, reg_wdata,
                  `GIB_MASK_PORT_REQ); // RQ8
            end
            `GIB_OFF_FIFO_TRIM: begin
               fifo_trim <= merge(fifo_trim, reg_wdata,
                  `GIB_MASK_FIFO_TRIM);
            end
            `GIB_OFF_LEGACY_A: begin
               legacy_a <= merge(legacy_a, reg_wdata,
                  `GIB_MASK_LEGACY_A);
            end
            `GIB_OFF_LEGACY_B: begin
               legacy_b <= merge(legacy_b, reg_wdata,
                  `GIB_MASK_LEGACY_B);
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always @* begin
      next_rdata = 32'h0000_0000;

      case (reg_addr)
         `GIB_OFF_MEM_FIRST: begin
            next_rdata = mem_first;
         end
         `GIB_OFF_MEM_SECOND: begin
            next_rdata = mem_second;
         end
         `GIB_OFF_PORT_REQ: begin
            next_rdata = port_req;
            next_rdata[`GIB_PR_OUTST] =
               outstanding_code(outstanding_count); // RQ8
         end
         `GIB_OFF_FIFO_TRIM: begin
            next_rdata = fifo_trim;
         end
         `GIB_OFF_LEGACY_A: begin
            next_rdata = legacy_a;
         end
         `GIB_OFF_LEGACY_B: begin
            next_rdata = legacy_b;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // memory setup outputs
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         memory_kind_sdram <= 1'b0;
         read_to_precharge_delay <= 2'h1;
         memory_density <= 3'h0;
         memory_chip_count <= 1'b0;
         dither_active <= 1'b0;
      end else begin
         memory_kind_sdram <= mem_second[`GIB_M2_SDRAM]; // RQ1
         read_to_precharge_delay <= {mem_second[`GIB_M2_TRL_HI],
            mem_first[`GIB_M1_TRL_LO]}; // RQ2

         if (mem_second[`GIB_M2_SDRAM]) begin
            memory_density <= `GIB_DENS_16MBIT; // RQ3
            memory_chip_count <= 1'b0; // RQ3
         end else begin
            memory_density <= mem_first[`GIB_M1_DENS];
            memory_chip_count <= mem_first[`GIB_M1_CHIPS];
         end
         dither_active <= dither_enable && !(fast_fill_active &&
            fast_fill_command_bit0 && !mem_second[`GIB_M2_SDRAM]); // RQ4
      end
   end

   // ----------------------------------------
   // port request tuning
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         port_high_priority <= 1'b0;
         request_queue_full <= 1'b0;
         port_request_stall <= 1'b0;
      end else begin
         port_high_priority <= port_req[`GIB_PR_PRIO]; // RQ5

         request_queue_full <= pending_request_count >=
            {1'b0, port_req[`GIB_PR_FULL]}; // RQ6
         port_request_stall <= returned_data_count >
            port_req[`GIB_PR_FILL]; // RQ7
      end
   end

   // ----------------------------------------
   // fifo marks, texture cache, clock trims
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         texture_sequence_active <= 1'b0;
         pixel_sequence_start <= 1'b0;
         texture_read_limit_off <= 1'b0;
         texture_min_reads_three <= 1'b0;
         texture_force_miss <= 1'b0;
         tv_clock_invert <= 1'b0;
         tv_clock_delay <= 4'h0;
         antialias_clock_invert <= 1'b0;
         antialias_clock_delay <= 4'h0;
         memory_port_layout <= 3'h0;
      end else begin
         if (texture_sequence_active) begin
            texture_sequence_active <= texture_free_space <
               fifo_trim[`GIB_FT_TEX_LOW]; // RQ9
         end else begin
            texture_sequence_active <= texture_free_space <
               fifo_trim[`GIB_FT_TEX_HIGH]; // RQ9
         end
         pixel_sequence_start <= pixel_free_space <
            fifo_trim[`GIB_FT_PIX_HIGH]; // RQ9

         texture_read_limit_off <= fifo_trim[`GIB_FT_NO_LIMIT]; // RQ10
         texture_min_reads_three <= fifo_trim[`GIB_FT_MIN3]; // RQ10
         texture_force_miss <= fifo_trim[`GIB_FT_MISS]; // RQ10

         tv_clock_invert <= fifo_trim[`GIB_FT_TV_INV]; // RQ11
         tv_clock_delay <= fifo_trim[`GIB_FT_TV_DEL]; // RQ11
         antialias_clock_invert <= fifo_trim[`GIB_FT_AA_INV]; // RQ11
         antialias_clock_delay <= fifo_trim[`GIB_FT_AA_DEL]; // RQ11
         memory_port_layout <= fifo_trim[`GIB_FT_PORT_CFG]; // RQ12
      end
   end

   // ----------------------------------------
   // legacy display setup
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         vga_core_disable <= 1'b0;
         palette_width_8bit <= 1'b1;
         legacy_decode_off <= 1'b0;
         enable_port_write_block <= 1'b0;
         wake_port_motherboard <= 1'b0;
         config_readback_enable <= 1'b1;
         raster_fetch_off <= 1'b0;
         vga_base_address <= 26'h000_0000;
         refresh_on_hblank <= 1'b0;
         bios_extension_write_aperture <= 12'h000;
         bios_extension_read_aperture <= 12'h000;
         chain4_sequential <= 1'b0;
         timing_lock <= 8'h00;
      end else begin
         vga_core_disable <= legacy_a[`GIB_LA_DISABLE]; // RQ13
         palette_width_8bit <= legacy_a[`GIB_LA_CLUT8]; // RQ14
         legacy_decode_off <= legacy_a[`GIB_LA_LEG_OFF] ||
            legacy_a[`GIB_LA_DEC_OFF]; // RQ15
         enable_port_write_block <= legacy_a[`GIB_LA_LEG_OFF]; // RQ15
         wake_port_motherboard <= legacy_a[`GIB_LA_WAKE]; // RQ16
         config_readback_enable <= !legacy_a[`GIB_LA_CFG_OFF]; // RQ17
         raster_fetch_off <= legacy_a[`GIB_LA_NO_FETCH]; // RQ18

         vga_base_address <= {legacy_a[`GIB_LA_BASE_HI],
            legacy_a[`GIB_LA_BASE_LO], 16'h0000}; // RQ19
         refresh_on_hblank <= !legacy_a[`GIB_LA_REF_TMO]; // RQ20

         bios_extension_write_aperture <= {legacy_b[`GIB_LB_WR_HI],
            legacy_b[`GIB_LB_WR_LO]}; // RQ21
         bios_extension_read_aperture <= {legacy_a[`GIB_LA_RD_HI],
            legacy_b[`GIB_LB_RD_LO]}; // RQ21
         chain4_sequential <= legacy_b[`GIB_LB_CHAIN4]; // RQ21
         timing_lock <= legacy_b[`GIB_LB_LOCKS]; // RQ22
      end
   end

endmodule
